// ### irq_host.sv
// host controller end: acknowledges level 6 and schedules logic blocks
// How it works
// - host alone handles levels five and seven
// - modules request program logic on level six
// - each source triggers exactly one logic block
// - upstream modules pass acknowledge chain downstream
// - module drops request after acknowledge ends
// - still-held request is serviced again
// - disabled source never scheduled, never unmasked
// - enabled source has runtime settable mask
// - mask request uses selector seventeen, offset id
// - acknowledge in run whether masked or not; schedule only when unmasked
// - stop-to-run clears masks of enabled sources
// - stuck request may trip watchdog to halt
`timescale 1ns/100ps
`default_nettype none
module irq_host
    import irq_pkg::*;
#(
    parameter int N = SRC_N,
    parameter int WDOG = WDOG_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // backplane
    irq_link.host link,
    // configuration: enable and the id each source answers with
    input wire logic [N-1:0] cfgEnable,
    input wire logic [N*ID_W-1:0] cfgId,
    // run control and watchdog kick from the application
    input wire logic runReq,
    input wire logic wdogKick,
    // mask service request: selector, offset carries the id
    input wire logic serviceRequestCall,
    input wire logic [7:0] memSelector,
    input wire logic [ID_W-1:0] memOffset,
    input wire logic maskValue,
    // scheduling: one pulse per triggered logic block
    output logic [N-1:0] blockTrigger,
    // status: run state, refused unmask, unmatched id
    output logic [1:0] hostMode,
    output logic maskRejected,
    output logic unknownId
);
    // watchdog counter width, wide enough to reach the window
    localparam int WW = $clog2(WDOG + 1);

    // controller state except the mask bits, registered in one place
    typedef struct packed {
        host_mode_t mode; // stopped, running or halted
        ack_state_t ack; // acknowledge sequence step
        logic [3:0] cnt; // strobe cycles counted so far
        logic [N-1:0] trig; // one-cycle block triggers
        logic unknown; // id matched no enabled source
        logic [WW-1:0] wdog; // cycles since the last kick
    } host_state_t;
    host_state_t st, next_st;

    // runtime mask, one bit per source, high means masked
    logic [N-1:0] mask;
    // sources addressed by the offset of a mask request
    logic [N-1:0] maskSel;
    // sources whose id the module returned at acknowledge end
    logic [N-1:0] idHit;
    // one-cycle stop-to-run transition
    logic startRun;
    // mask request carrying the right selector
    logic maskReq;

    // decode which source carries a given id; used for requests and acknowledges
    function automatic logic [N-1:0] matchId(input logic [ID_W-1:0] id,
                                            input logic [N*ID_W-1:0] tab);
        // one bit per table entry
        logic [N-1:0] r;
        r = '0;
        // compare every slot, several may match if ids repeat
        for (int i = 0; i < N; i++) begin
            r[i] = (tab[i*ID_W +: ID_W] == id);
        end
        return r;
    endfunction

    assign maskReq = serviceRequestCall && (memSelector == INTERRUPT_ID_MEMORY_SELECTOR);
    assign maskSel = matchId(memOffset, cfgId);
    // source answering the acknowledge
    assign idHit = matchId(link.ackId, cfgId);
    assign startRun = (st.mode == HOST_STOP) && runReq;

    // mask bits
    // refusals of an unmask come straight from the bank
    irq_mask_bank #(.N(N)) masks (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .cfgEnable(cfgEnable),
        .startRun(startRun),
        .maskReq(maskReq),
        .maskSel(maskSel),
        .maskValue(maskValue),
        .mask(mask),
        .maskRejected(maskRejected)
    );

    // mode, acknowledge sequence and watchdog
    always_comb begin
        // hold by default; pulses fall back to zero
        next_st = st;
        next_st.trig = '0;
        next_st.unknown = 1'b0;
        // run state and watchdog window
        unique case (st.mode)
            // stopped: wait for the application to ask for run
            HOST_STOP: begin
                if (runReq) begin
                    // window starts afresh on entering run
                    next_st.mode = HOST_RUN;
                    next_st.wdog = '0;
                end
            end
            // running: watch the kicks
            HOST_RUN: begin
                if (!runReq) begin
                    // application dropped run
                    next_st.mode = HOST_STOP;
                end else if (wdogKick) begin
                    // kick restarts the window
                    next_st.wdog = '0;
                end else if (st.wdog == WW'(WDOG)) begin
                    next_st.mode = HOST_HALT;
                end else begin
                    // one more cycle without a kick
                    next_st.wdog = st.wdog + WW'(1);
                end
            end
            // halted: sticks until reset
            HOST_HALT: begin
                next_st.mode = HOST_HALT;
            end
            // unused code falls back to stop
            default: next_st.mode = HOST_STOP;
        endcase
        // acknowledge sequence runs beside the run state
        unique case (st.ack)
            // idle: wait for the line to go low
            ACK_IDLE: begin
                if (st.mode == HOST_RUN && !link.irq6Request_b) begin
                    next_st.ack = ACK_BUSY;
                    next_st.cnt = '0;
                end
            end
            // strobe stands while the count runs
            ACK_BUSY: begin
                if (st.cnt == ACK_CYCLES) begin
                    // last strobe cycle: end marker and scheduling next
                    next_st.ack = ACK_DONE;
                    next_st.trig = idHit & cfgEnable & ~mask;
                    // flag an id that no enabled source owns
                    next_st.unknown = ~|(idHit & cfgEnable);
                end else begin
                    // one more strobe cycle
                    next_st.cnt = st.cnt + 4'h1;
                end
            end
            // end marker stands one cycle
            ACK_DONE: begin
                next_st.ack = ACK_IDLE;
            end
            // unused code returns to idle
            default: next_st.ack = ACK_IDLE;
        endcase
    end

    // register
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            // synchronous reset: stopped, idle, no pulses
            st <= '{mode: HOST_STOP, ack: ACK_IDLE, cnt: '0, trig: '0,
                    unknown: 1'b0, wdog: '0};
        end else begin
            // take the next state
            st <= next_st;
        end
    end

    assign link.ackStrobe = (st.ack == ACK_BUSY);
    // fixed level: only six is acknowledged here
    assign link.ackLevel = LEVEL_PROG;
    // chain starts at the host while the strobe stands
    assign link.ackChainIn = (st.ack == ACK_BUSY);
    // one-cycle end of the acknowledge
    assign link.ackDone = (st.ack == ACK_DONE);
    // registered pulses and state to the application
    assign blockTrigger = st.trig;
    // run state shown as a plain code
    assign hostMode = st.mode;
    // pulse when the returned id owns no enabled source
    assign unknownId = st.unknown;
endmodule
`default_nettype wire

// ### irq_link.sv
// backplane wires between interrupter modules and the host controller
`timescale 1ns/100ps
`default_nettype none
interface irq_link;
    import irq_pkg::*;
    // level 6 request, active low open drain: each module drives an enable
    logic irq6RequestOe_b;
    logic irq6Request_b;
    // acknowledge strobe and the level being acknowledged
    logic ackStrobe;
    logic [2:0] ackLevel;
    // daisy chain into this slot and out to the next slot
    logic ackChainIn;
    logic ackChainOut;
    // end of acknowledge cycle, with the id the module returned
    logic ackDone;
    logic [ID_W-1:0] ackId;
    // wired level: low while enable (active low) asserts drive
    assign irq6Request_b = irq6RequestOe_b;
    modport host (
        input irq6Request_b, ackId,
        output ackStrobe, ackLevel, ackChainIn, ackDone
    );
    modport module_end (
        input ackStrobe, ackLevel, ackChainIn, ackDone,
        output irq6RequestOe_b, ackChainOut, ackId
    );
endinterface
`default_nettype wire

// ### irq_link_checker.sv
// assertions on the level 6 link between host and module
`timescale 1ns/100ps
`default_nettype none
module irq_link_checker
    import irq_pkg::*;
#(
    parameter logic [ID_W-1:0] MY_ID = '0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // link signals
    input wire logic irq6RequestOe_b,
    input wire logic irq6Request_b,
    input wire logic ackStrobe,
    input wire logic [2:0] ackLevel,
    input wire logic ackChainIn,
    input wire logic ackChainOut,
    input wire logic ackDone,
    input wire logic [ID_W-1:0] ackId
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_level_six: assert property (ackStrobe |-> ackLevel == LEVEL_PROG)
        else $error("acknowledge on wrong level");
    a_chain_fed: assert property (ackChainIn == ackStrobe)
        else $error("chain input not following strobe");
    a_chain_blocked: assert property (!irq6RequestOe_b |-> !ackChainOut)
        else $error("chain passed by requesting module");
    a_strobe_len: assert property ($rose(ackStrobe) |->
        ackStrobe[*4] ##1 (!ackStrobe && ackDone))
        else $error("acknowledge strobe length wrong");
    a_taken_request: assert property ($rose(ackStrobe) |-> !$past(irq6Request_b))
        else $error("acknowledge without request");
    a_hold_request: assert property ($rose(irq6RequestOe_b) |-> $past(ackDone))
        else $error("request released at wrong time");
    a_reservice: assert property (ackDone ##1 !irq6Request_b |=> ackStrobe)
        else $error("held request not serviced again");
    a_id_done: assert property (ackDone |-> ackId == MY_ID)
        else $error("wrong id at acknowledge end");
    // single cycle end marker
    a_done_pulse: assert property (ackDone |=> !ackDone)
        else $error("acknowledge end longer than one cycle");
    // main scenarios
    c_ack: cover property ($rose(ackStrobe));
    c_again: cover property (ackDone ##1 !irq6Request_b);
    c_release: cover property ($rose(irq6RequestOe_b));
endmodule
`default_nettype wire

// ### irq_mask_bank.sv
// runtime mask bits, one per configured interrupt source
`timescale 1ns/100ps
`default_nettype none
module irq_mask_bank
    import irq_pkg::*;
#(
    parameter int N = SRC_N
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // configuration enables and run transition
    input wire logic [N-1:0] cfgEnable,
    input wire logic startRun,
    // mask request
    input wire logic maskReq,
    input wire logic [N-1:0] maskSel,
    input wire logic maskValue,
    // state
    output logic [N-1:0] mask,
    output logic maskRejected
);
    typedef struct packed {
        logic [N-1:0] mask;
        logic rejected;
    } mask_state_t;
    mask_state_t st, next_st;

    // mask update
    always_comb begin
        next_st = st;
        next_st.rejected = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (!cfgEnable[i]) begin
                next_st.mask[i] = 1'b1;
                if (maskReq && maskSel[i] && !maskValue) begin
                    next_st.rejected = 1'b1;
                end
            end else if (startRun) begin
                next_st.mask[i] = 1'b0;
            end else if (maskReq && maskSel[i]) begin
                next_st.mask[i] = maskValue;
            end
        end
    end

    // register
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st <= '{mask: '1, rejected: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign mask = st.mask;
    assign maskRejected = st.rejected;
endmodule
`default_nettype wire

// ### irq_module.sv
// interrupter module end: raises level 6 and passes the acknowledge chain
`timescale 1ns/100ps
`default_nettype none
module irq_module
    import irq_pkg::*;
#(
    parameter logic [ID_W-1:0] MY_ID = '0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // backplane
    irq_link.module_end link,
    // user side: one-cycle event asks for service
    input wire logic raise,
    output logic pending,
    output logic serviced
);
    typedef struct packed {
        logic pend;
        logic mine;
        logic done;
    } mod_state_t;
    mod_state_t st, next_st;

    // only level six answered, never handler levels
    logic ackForMe;
    assign ackForMe = link.ackStrobe && link.ackChainIn && (link.ackLevel == LEVEL_PROG);

    // request hold and release
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (st.pend && ackForMe) begin
            next_st.mine = 1'b1;
        end
        if (st.mine && link.ackDone) begin
            next_st.pend = 1'b0;
            next_st.mine = 1'b0;
            next_st.done = 1'b1;
        end
        // hold until acknowledged; a new raise wins
        if (raise) begin
            next_st.pend = 1'b1;
        end
    end

    // register
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st <= '{pend: 1'b0, mine: 1'b0, done: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // open drain: enable low drives the line low
    assign link.irq6RequestOe_b = ~st.pend;
    // pass chain when not claiming it
    assign link.ackChainOut = link.ackChainIn && !st.pend;
    assign link.ackId = st.mine ? MY_ID : '0;
    assign pending = st.pend;
    assign serviced = st.done;
endmodule
`default_nettype wire

// ### irq_pkg.sv
// shared constants and types for the level 6 interrupt path
`default_nettype none
package irq_pkg;
    // interrupt levels on the backplane (1..7), 3-bit acknowledge code
    localparam logic [2:0] LEVEL_PROG = 3'h6;
    localparam logic [2:0] LEVEL_LO_HOST = 3'h5;
    localparam logic [2:0] LEVEL_HI_HOST = 3'h7;
    // memory-type selector value for mask requests
    localparam logic [7:0] INTERRUPT_ID_MEMORY_SELECTOR = 8'h11;
    // default width of an interrupt identifier
    localparam int ID_W = 8;
    // default number of interrupt sources handled by the controller
    localparam int SRC_N = 4;
    // last strobe count on the host side; the strobe stands ACK_CYCLES+1 clocks
    localparam logic [3:0] ACK_CYCLES = 4'h3;
    // watchdog window in clocks before a stuck source halts the host
    localparam int WDOG_CYCLES = 1000;
    // controller run state
    typedef enum logic [1:0] {
        HOST_STOP = 2'b00,
        HOST_RUN = 2'b01,
        HOST_HALT = 2'b10
    } host_mode_t;
    // acknowledge sequence states
    typedef enum logic [1:0] {
        ACK_IDLE = 2'b00,
        ACK_BUSY = 2'b01,
        ACK_DONE = 2'b10
    } ack_state_t;
endpackage
`default_nettype wire

// ### vme_irq6_logic_trigger_test.sv
// self-checking bench joining host and module over the level 6 link
`timescale 1ns/100ps
`default_nettype none
module vme_irq6_logic_trigger_test;
    import irq_pkg::*;
    // arbitrary module id
    localparam logic [ID_W-1:0] MOD_ID = 8'h5a;
    // offset of a mask request, normally the module's id
    logic [ID_W-1:0] memOffset = MOD_ID;
    // clock, reset and run control
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic runReq = 1'b0;
    logic wdogKick = 1'b0;
    logic kickOn = 1'b1;
    // configuration, mask request, user side
    logic [3:0] cfgEnable = 4'hf;
    logic serviceRequestCall = 1'b0;
    logic [7:0] memSelector = 8'h00;
    logic maskValue = 1'b0;
    logic raise = 1'b0;
    // observed outputs
    logic [3:0] blockTrigger;
    logic [1:0] hostMode;
    logic maskRejected, unknownId, pending, serviced;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    irq_link link();
    irq_host #(.N(4), .WDOG(20)) u_irq_host (.ref_clk(ref_clk), .rst_b(rst_b), .link(link),
        .cfgEnable(cfgEnable), .cfgId({8'h24, 8'h23, 8'h22, MOD_ID}), .runReq(runReq),
        .wdogKick(wdogKick), .serviceRequestCall(serviceRequestCall),
        .memSelector(memSelector), .memOffset(memOffset), .maskValue(maskValue),
        .blockTrigger(blockTrigger), .hostMode(hostMode), .maskRejected(maskRejected),
        .unknownId(unknownId));
    irq_module #(.MY_ID(MOD_ID)) u_irq_module (.ref_clk(ref_clk), .rst_b(rst_b),
        .link(link), .raise(raise), .pending(pending), .serviced(serviced));
    irq_link_checker #(.MY_ID(MOD_ID)) u_irq_link_checker (.ref_clk(ref_clk),
        .rst_b(rst_b), .irq6RequestOe_b(link.irq6RequestOe_b),
        .irq6Request_b(link.irq6Request_b), .ackStrobe(link.ackStrobe),
        .ackLevel(link.ackLevel), .ackChainIn(link.ackChainIn),
        .ackChainOut(link.ackChainOut), .ackDone(link.ackDone), .ackId(link.ackId));
    // free running clock
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // watchdog kicks and hang limit
    always @(negedge ref_clk) begin
        cyc <= cyc + 1;
        wdogKick <= kickOn && (cyc % 8 == 0);
        if (cyc == 4000) begin
            num_errors++;
            conclude();
        end
    end
    // counts a comparison, reports a mismatch
    task automatic check(input bit ok, input string msg);
        n_checks++;
        if (!ok) begin
            num_errors++;
            $display("mismatch %0t %s", $time, msg);
        end
    endtask
    // verdict and end of run
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // reset held six cycles
    task automatic do_reset();
        rst_b = 1'b0;
        repeat (6) @(negedge ref_clk);
        rst_b = 1'b1;
    endtask
    // one-cycle raise pulse
    task automatic pulse_raise();
        raise = 1'b1;
        @(negedge ref_clk);
        raise = 1'b0;
    endtask
    // raise, then n services; raising again at each end but the last
    task automatic serve(input int n, input logic [3:0] exp);
        int k;
        pulse_raise();
        for (int i = 0; i < n; i++) begin
            k = 0;
            while (link.ackDone !== 1'b1 && k < 30) begin
                @(negedge ref_clk);
                k++;
            end
            check(link.ackDone === 1'b1, "no acknowledge end");
            check(blockTrigger === exp, "wrong block trigger");
            check(unknownId === !cfgEnable[0], "unknown id flag");
            raise = (i < n - 1);
            @(negedge ref_clk);
            raise = 1'b0;
        end
        check(pending === 1'b0 && serviced === 1'b1, "request not released");
    endtask
    // mask request, refusal looked at one cycle later
    task automatic mreq(input logic [7:0] sel, input logic val, input logic rej);
        serviceRequestCall = 1'b1;
        memSelector = sel;
        maskValue = val;
        @(negedge ref_clk);
        serviceRequestCall = 1'b0;
        check(maskRejected === rej, "mask refusal");
        @(negedge ref_clk);
    endtask
    // request in stop waits, run start clears mask
    task automatic t_stop_run();
        pulse_raise();
        repeat (10) @(negedge ref_clk);
        check(pending === 1'b1 && link.ackStrobe === 1'b0, "serviced in stop");
        runReq = 1'b1;
        serve(1, 4'h1);
        check(hostMode === 2'h1, "not running");
    endtask
    // mask, wrong selector, unmask
    task automatic t_mask();
        mreq(8'h11, 1'b1, 1'b0);
        serve(1, 4'h0);
        mreq(8'h10, 1'b0, 1'b0);
        serve(1, 4'h0);
        mreq(8'h11, 1'b0, 1'b0);
        serve(1, 4'h1);
        // mask aimed at another source's id leaves the module unmasked
        memOffset = 8'h23;
        mreq(8'h11, 1'b1, 1'b0);
        memOffset = MOD_ID;
        serve(1, 4'h1);
    endtask
    // disabled source refuses unmask and never triggers
    task automatic t_disabled();
        cfgEnable = 4'he;
        mreq(8'h11, 1'b1, 1'b0);
        mreq(8'h11, 1'b0, 1'b1);
        serve(1, 4'h0);
        cfgEnable = 4'hf;
    endtask
    // missing kicks halt the host, reset recovers
    task automatic t_watchdog();
        kickOn = 1'b0;
        repeat (30) @(negedge ref_clk);
        check(hostMode === 2'h2, "no halt");
        pulse_raise();
        repeat (10) @(negedge ref_clk);
        check(pending === 1'b1 && link.ackStrobe === 1'b0, "serviced in halt");
        do_reset();
        check(hostMode === 2'h0 && pending === 1'b0, "reset state");
    endtask
    // main sequence
    initial begin
        do_reset();
        t_stop_run();
        t_mask();
        serve(2, 4'h1);
        t_disabled();
        t_watchdog();
        conclude();
    end
endmodule
`default_nettype wire
